// ===== shared/cmr_pkg.sv
// Shared constants and types for the control message port router
// What this block does
// RULE1 - Exactly four message ports: serial bus, network card, signal link, power link.
// RULE2 - Each module holds its own unique control address, also inside a cluster.
// RULE3 - Messages to the single global address are accepted by every module.
// RULE4 - Compare each received message address with own address; use it on a match.
// RULE5 - Non-matching messages repeat on all other ports, never back out the arrival port.
// RULE6 - Serial bus traffic goes to both links, and to the card when fitted.
// RULE7 - The serial bus control port runs at 115200 bits per second.
// RULE8 - A setting enables or disables bridging between serial bus and card port.
// RULE9 - Link ports carry messages from the serial bus and, if fitted, the card.
// RULE10 - Network audio uses only multicast bundles numbered 1 through 255.
// RULE11 - A reply leaves through the port on which the original message arrived.
// RULE12 - Own-address messages are consumed only; global ones are consumed and forwarded.
package cmr_pkg;

	// Port map, one bit per port in every mask
	localparam int          NPORT   = 4;
	localparam logic [1:0]  P_SER   = 2'h0;
	localparam logic [1:0]  P_CARD  = 2'h1;
	localparam logic [1:0]  P_SLINK = 2'h2;
	localparam logic [1:0]  P_POWER_END_LINK_PORT = 2'h3;
	localparam logic [3:0]  MASK_NONE = 4'h0;
	localparam logic [3:0]  MASK_ONE  = 4'h1;

	// Message layout
	localparam int          ADDR_W      = 8;
	localparam int          BODY_W      = 24;
	localparam logic [7:0]  GLOBAL_ADDR = 8'hFF;

	// Serial bus bit rate and derived bit period in clock cycles
	localparam longint      CLK_HZ      = 200000000;
	localparam longint      SER_BPS     = 115200;
	localparam int          BIT_CYC     = int'(CLK_HZ / SER_BPS);
	localparam logic [10:0] BIT_CYC_M1  = 11'(BIT_CYC - 1);
	localparam logic [10:0] BAUD_ZERO   = 11'h000;
	localparam logic [10:0] BAUD_ONE    = 11'h001;

	// Permitted multicast bundle numbers
	localparam logic [15:0] BUNDLE_MIN  = 16'h0001;
	localparam logic [15:0] BUNDLE_MAX  = 16'h00FF;

	// Receive buffer depth in messages
	localparam int          FIFO_DEPTH  = 8;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [BODY_W-1:0] body;
	} cmr_msg_s;

	typedef struct packed {
		cmr_msg_s   msg;
		logic [1:0] src;
	} cmr_entry_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SEND = 2'b10
	} cmr_state_e;

endpackage : cmr_pkg

// ===== rtl/cmr_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module cmr_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem_q [DEPTH];
	logic [W-1:0]  mem_d [DEPTH];
	logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic          push, pop;

	// Full and empty come straight from the occupancy count
	assign in_ready  = (cnt_q != CW'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Next pointers, count and storage
	always_comb
	begin
		wr_d  = wr_q;
		rd_d  = rd_q;
		cnt_d = cnt_q;
		for (int i = 0; i < DEPTH; i++)
			mem_d[i] = mem_q[i];
		if (push)
		begin
			mem_d[wr_q] = in_data;
			wr_d        = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
		end
		if (pop)
			rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
		if (push && !pop)
			cnt_d = cnt_q + 1'b1;
		else if (pop && !push)
			cnt_d = cnt_q - 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
			for (int i = 0; i < DEPTH; i++)
				mem_q[i] <= '0;
		end
		else
		begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
			for (int i = 0; i < DEPTH; i++)
				mem_q[i] <= mem_d[i];
		end
	end

	a_fifo_no_overflow : assert property (@(posedge clk) disable iff (rst)
		cnt_q <= CW'(DEPTH)) else $error("FIFO count beyond depth");

endmodule : cmr_fifo

// ===== rtl/cmr_router.sv
// Control message router: four ports, own and global address match, blind repeat
`timescale 1ns/1ps
module cmr_router
	import cmr_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] own_addr,
	input  wire logic              card_present_pin,
	input  wire logic              bridge_en,
	input  wire logic [15:0]       bundle_num,
	input  wire logic [NPORT-1:0]  in_valid,
	input  wire cmr_msg_s [NPORT-1:0] in_msg,
	output logic [NPORT-1:0]       in_ready,
	output logic [NPORT-1:0]       out_valid,
	output cmr_msg_s               out_msg,
	input  wire logic [NPORT-1:0]  out_ready,
	output logic                   cons_valid,
	output cmr_msg_s               cons_msg,
	output logic [1:0]             cons_src,
	output logic                   cons_global,
	input  wire logic              reply_valid,
	input  wire cmr_msg_s          reply_msg,
	output logic                   reply_ready,
	output logic                   card_usable,
	output logic                   ser_bit_tick
);

	// Card presence pin crossing into the clock domain
	logic card_meta_q, card_sync_q;
	logic card_meta_d, card_sync_d;
	logic card_ok_q, card_ok_d;

	always_comb
	begin
		card_meta_d = card_present_pin;
		card_sync_d = card_meta_q;
		// Card is used only with a permitted multicast bundle
		card_ok_d   = card_sync_q && (bundle_num >= BUNDLE_MIN)
		              && (bundle_num <= BUNDLE_MAX); // RULE10
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			card_meta_q <= 1'b0;
			card_sync_q <= 1'b0;
			card_ok_q   <= 1'b0;
		end
		else
		begin
			card_meta_q <= card_meta_d;
			card_sync_q <= card_sync_d;
			card_ok_q   <= card_ok_d;
		end
	end

	assign card_usable = card_ok_q;

	// Bit-rate enable for the serial bus transceiver
	logic [10:0] baud_q, baud_d;
	logic        tick_q, tick_d;

	always_comb
	begin
		tick_d = (baud_q == BIT_CYC_M1); // RULE7
		baud_d = tick_d ? BAUD_ZERO : baud_q + BAUD_ONE;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			baud_q <= BAUD_ZERO;
			tick_q <= 1'b0;
		end
		else
		begin
			baud_q <= baud_d;
			tick_q <= tick_d;
		end
	end

	assign ser_bit_tick = tick_q;

	// Round-robin intake of the four ports into one buffer
	logic [1:0]       rr_q, rr_d;
	logic [NPORT-1:0] elig;
	logic [NPORT-1:0] grant;
	logic [1:0]       pick;
	logic             fifo_in_ready;
	cmr_entry_s       fifo_in, fifo_out;
	logic             fifo_out_valid, pop;

	// The card port takes nothing while it is absent or misconfigured
	always_comb
	begin
		elig         = in_valid;
		elig[P_CARD] = in_valid[P_CARD] & card_ok_q; // RULE1
	end

	always_comb
	begin
		logic [1:0] idx;
		idx   = 2'h0;
		pick  = 2'h0;
		grant = MASK_NONE;
		for (int k = NPORT - 1; k >= 0; k--)
		begin
			idx = rr_q + 2'(k);
			if (elig[idx])
				pick = idx;
		end
		if (|elig)
			grant = MASK_ONE << pick;
		rr_d = (|elig && fifo_in_ready) ? pick + 2'h1 : rr_q;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rr_q <= 2'h0;
		else
			rr_q <= rr_d;
	end

	assign in_ready    = grant & {NPORT{fifo_in_ready}};
	assign fifo_in.msg = in_msg[pick];
	assign fifo_in.src = pick;

	cmr_fifo #(
		.W     ($bits(cmr_entry_s)),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (|elig),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (fifo_out_valid),
		.out_ready (pop),
		.out_data  (fifo_out)
	);

	// Destination mask for a repeated message
	function automatic logic [3:0] fwd_mask(input logic [1:0] src,
	                                         input logic card, input logic bridge);
		logic [3:0] m;
		m = ~(MASK_ONE << src); // RULE5
		if (!card || (!bridge && src == P_SER))
			m[P_CARD] = 1'b0; // RULE6
		if (!bridge && src == P_CARD)
			m[P_SER] = 1'b0; // RULE8
		return m; // RULE9
	endfunction : fwd_mask

	// Router state: consume, repeat or reply, one message at a time
	cmr_state_e   state_q, state_d;
	logic [3:0]   pend_q, pend_d;
	logic [3:0]   rep_mask_q, rep_mask_d;
	logic [1:0]   cur_src_q, cur_src_d;
	logic         fwd_q, fwd_d;
	cmr_msg_s     out_msg_q, out_msg_d;
	logic         cons_valid_q, cons_valid_d;
	cmr_msg_s     cons_msg_q, cons_msg_d;
	logic [1:0]   cons_src_q, cons_src_d;
	logic         cons_glob_q, cons_glob_d;
	logic         is_own, is_glob;

	assign is_own  = (fifo_out.msg.addr == own_addr); // RULE2
	assign is_glob = (fifo_out.msg.addr == GLOBAL_ADDR);

	// Replies take priority so a waiting host is answered before new traffic
	always_comb
	begin
		state_d      = state_q;
		pend_d       = pend_q;
		rep_mask_d   = rep_mask_q;
		cur_src_d    = cur_src_q;
		fwd_d        = fwd_q;
		out_msg_d    = out_msg_q;
		cons_valid_d = 1'b0;
		cons_msg_d   = cons_msg_q;
		cons_src_d   = cons_src_q;
		cons_glob_d  = cons_glob_q;
		pop          = 1'b0;
		reply_ready  = 1'b0;
		case (state_q)
			ST_IDLE:
			begin
				if (reply_valid)
				begin
					reply_ready = 1'b1;
					out_msg_d   = reply_msg;
					fwd_d       = 1'b0;
					pend_d      = rep_mask_q; // RULE11
					if (rep_mask_q != MASK_NONE)
						state_d = ST_SEND;
				end
				else if (fifo_out_valid)
				begin
					pop       = 1'b1;
					cur_src_d = fifo_out.src;
					if (is_own || is_glob) // RULE4
					begin
						cons_valid_d = 1'b1; // RULE3
						cons_msg_d   = fifo_out.msg;
						cons_src_d   = fifo_out.src;
						cons_glob_d  = !is_own;
						rep_mask_d   = MASK_ONE << fifo_out.src;
					end
					// Own address stops here; global is repeated as well
					if (!is_own) // RULE12
					begin
						fwd_d     = 1'b1;
						out_msg_d = fifo_out.msg;
						pend_d    = fwd_mask(fifo_out.src, card_ok_q, bridge_en);
						state_d   = ST_SEND;
					end
				end
			end
			ST_SEND:
			begin
				// Each port drops out as it accepts; hold until all have
				pend_d = pend_q & ~out_ready;
				if (pend_d == MASK_NONE)
					state_d = ST_IDLE;
			end
			default:
			begin
				state_d = ST_IDLE;
				pend_d  = MASK_NONE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q      <= ST_IDLE;
			pend_q       <= MASK_NONE;
			rep_mask_q   <= MASK_NONE;
			cur_src_q    <= P_SER;
			fwd_q        <= 1'b0;
			out_msg_q    <= '0;
			cons_valid_q <= 1'b0;
			cons_msg_q   <= '0;
			cons_src_q   <= P_SER;
			cons_glob_q  <= 1'b0;
		end
		else
		begin
			state_q      <= state_d;
			pend_q       <= pend_d;
			rep_mask_q   <= rep_mask_d;
			cur_src_q    <= cur_src_d;
			fwd_q        <= fwd_d;
			out_msg_q    <= out_msg_d;
			cons_valid_q <= cons_valid_d;
			cons_msg_q   <= cons_msg_d;
			cons_src_q   <= cons_src_d;
			cons_glob_q  <= cons_glob_d;
		end
	end

	assign out_valid   = pend_q;
	assign out_msg     = out_msg_q;
	assign cons_valid  = cons_valid_q;
	assign cons_msg    = cons_msg_q;
	assign cons_src    = cons_src_q;
	assign cons_global = cons_glob_q;

	// Checks on the routing decisions and the serial bit-rate enable
	a_fwd_not_src : assert property (@(posedge clk) disable iff (rst) // RULE5
		(state_q == ST_SEND && fwd_q) |-> !pend_q[cur_src_q])
		else $error("Message repeated back out of its arrival port");

	a_own_consumed : assert property (@(posedge clk) disable iff (rst) // RULE12
		(pop && is_own) |=> (cons_valid_q && !cons_glob_q && state_q == ST_IDLE))
		else $error("Own-address message not consumed alone");

	a_glob_both : assert property (@(posedge clk) disable iff (rst) // RULE3
		(pop && is_glob && !is_own) |=> (cons_valid_q && cons_glob_q && state_q == ST_SEND))
		else $error("Global message not consumed and repeated");

	a_ser_to_links : assert property (@(posedge clk) disable iff (rst) // RULE6
		(pop && !is_own && !is_glob && fifo_out.src == P_SER)
		|=> (pend_q[P_SLINK] && pend_q[P_POWER_END_LINK_PORT] && !pend_q[P_SER]))
		else $error("Serial bus message missed a link port");

	a_bridge_off : assert property (@(posedge clk) disable iff (rst) // RULE8
		(pop && !is_own && !bridge_en && fifo_out.src == P_SER) |=> !pend_q[P_CARD])
		else $error("Serial traffic bridged to card while disabled");

	a_bit_period : assert property (@(posedge clk) disable iff (rst) // RULE7
		ser_bit_tick |=> (!ser_bit_tick && baud_q == BAUD_ONE))
		else $error("Bit-rate enable period wrong");

	a_reply_port : assert property (@(posedge clk) disable iff (rst) // RULE11
		(reply_valid && reply_ready) |=> ((pend_q & ~$past(rep_mask_q)) == MASK_NONE))
		else $error("Reply sent out of a port the original did not use");

	a_bundle_range : assert property (@(posedge clk) disable iff (rst) // RULE10
		card_usable |-> ($past(bundle_num) >= BUNDLE_MIN && $past(bundle_num) <= BUNDLE_MAX))
		else $error("Card used with bundle out of range");

	a_card_absent : assert property (@(posedge clk) disable iff (rst) // RULE1
		!card_usable |-> !in_ready[P_CARD])
		else $error("Card port accepted traffic without a usable card");

	a_match_used : assert property (@(posedge clk) disable iff (rst) // RULE4
		(pop && is_own) |=> (cons_msg_q == $past(fifo_out.msg)))
		else $error("Matching message not handed to the module");

endmodule : cmr_router

// ===== test/cmr_far_side.sv
// Far-side model: host and neighbour modules taking repeated messages
`timescale 1ns/1ps
module cmr_far_side
	import cmr_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [NPORT-1:0] out_valid,
	input  wire cmr_msg_s         out_msg,
	input  wire logic             stall,
	input  wire logic             slow,
	input  wire logic             clr,
	output logic [NPORT-1:0]      out_ready,
	output logic [NPORT-1:0]      got,
	output cmr_msg_s              last_msg,
	output int                    n_ser
);
	logic phase;

	// Ready moves on the falling edge so it is settled when sampled; slow answers every other cycle
	always @(negedge clk or posedge rst)
	begin
		if (rst)
		begin
			phase <= 1'b0;
			out_ready <= 4'h0;
		end
		else
		begin
			phase <= ~phase;
			out_ready <= (stall || (slow && phase)) ? 4'h0 : out_valid;
		end
	end

	// Record which ports took a message and the last one taken
	always @(posedge clk)
	begin
		if (clr)
			got <= 4'h0;
		else
			got <= got | (out_valid & out_ready);
		if ((out_valid & out_ready) != 4'h0)
			last_msg <= out_msg;
		if (out_valid[0] && out_ready[0])
			n_ser <= n_ser + 1;
	end
	initial n_ser = 0;
endmodule : cmr_far_side

// ===== test/test_cmr_router.sv
// Self-checking bench for the control message router
`timescale 1ns/1ps
`define CHK(nm, exp, seen) begin n_compared++; if ((seen) !== (exp)) begin failures++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen); end end
module test_cmr_router
	import cmr_pkg::*;
;
	logic                       clk = 1'b0;
	logic                       rst = 1'b1;
	logic [ADDR_W-1:0]          own_addr = 8'h05;
	logic                       card_pin = 1'b1;
	logic                       bridge_en = 1'b1;
	logic [15:0]                bundle_num = 16'h0001;
	logic [NPORT-1:0]           in_valid = 4'h0;
	cmr_msg_s [NPORT-1:0]       in_msg = '0;
	logic [NPORT-1:0]           in_ready, out_valid, out_ready, got;
	cmr_msg_s                   out_msg, cons_msg, reply_msg = '0, last_msg;
	logic                       cons_valid, cons_global, reply_valid = 1'b0, reply_ready;
	logic [1:0]                 cons_src;
	logic                       card_usable, ser_bit_tick, cons_seen;
	logic                       stall = 1'b0, slow = 1'b0, clr = 1'b0;
	int                         failures = 0, n_compared = 0, n_ser, cyc = 0, k;

	always #2.5 clk = ~clk;

	cmr_router DUT (.clk(clk), .rst(rst), .own_addr(own_addr), .card_present_pin(card_pin),
		.bridge_en(bridge_en), .bundle_num(bundle_num), .in_valid(in_valid), .in_msg(in_msg),
		.in_ready(in_ready), .out_valid(out_valid), .out_msg(out_msg), .out_ready(out_ready),
		.cons_valid(cons_valid), .cons_msg(cons_msg), .cons_src(cons_src),
		.cons_global(cons_global), .reply_valid(reply_valid), .reply_msg(reply_msg),
		.reply_ready(reply_ready), .card_usable(card_usable), .ser_bit_tick(ser_bit_tick));

	cmr_far_side far (.clk(clk), .rst(rst), .out_valid(out_valid), .out_msg(out_msg),
		.stall(stall), .slow(slow), .clr(clr), .out_ready(out_ready), .got(got),
		.last_msg(last_msg), .n_ser(n_ser));

	// Consume pulse lasts one cycle, so latch it
	always @(posedge clk)
		if (cons_valid === 1'b1)
			cons_seen <= 1'b1;

	task automatic close_out();
	begin
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
	endtask : close_out

	// Cut a hang short; the whole run needs well under this
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			failures++;
			close_out();
		end
	end

	// Offer one message, held until the edge where ready is high
	task automatic put(input int p, input logic [7:0] a);
		int i;
		in_msg[p] = cmr_msg_s'{addr: a, body: {16'hC0DE, a}};
		in_valid[p] = 1'b1;
		for (i = 0; i < 50; i++)
		begin
			#1;
			if (in_ready[p] === 1'b1)
				break;
			@(negedge clk);
		end
		@(negedge clk);
		in_valid[p] = 1'b0;
		`CHK("offer taken", 1'b1, (i < 50))
		// Let an edge pass so a following offer never re-raises valid in the same step
		@(negedge clk);
	endtask : put

	// Send one message and judge where it went
	task automatic route(input int p, input logic [7:0] a, input logic [3:0] m, input logic c);
		clr = 1'b1;
		cons_seen = 1'b0;
		@(negedge clk);
		clr = 1'b0;
		put(p, a);
		repeat (30) @(negedge clk);
		`CHK("forward mask", m, got)
		`CHK("consumed", c, cons_seen)
		if (m != 4'h0)
			`CHK("forwarded msg", {a, 16'hC0DE, a}, last_msg)
		if (c)
			`CHK("arrival port", p[1:0], cons_src)
		if (c)
			`CHK("consumed msg", {a, 16'hC0DE, a}, cons_msg)
	endtask : route

	// Local reply goes back out of the arrival port of the last consumed message
	task automatic reply(input logic [3:0] m);
		clr = 1'b1;
		@(negedge clk);
		clr = 1'b0;
		reply_msg = cmr_msg_s'{addr: 8'h01, body: 24'hBEEF01};
		reply_valid = 1'b1;
		for (k = 0; k < 20; k++)
		begin
			#1;
			if (reply_ready === 1'b1)
				break;
			@(negedge clk);
		end
		@(negedge clk);
		reply_valid = 1'b0;
		repeat (10) @(negedge clk);
		`CHK("reply mask", m, got)
		`CHK("reply msg", reply_msg, last_msg)
	endtask : reply

	// Fill the buffer with the far side stalled, then drain it
	task automatic fill_drain();
		int base;
		base = n_ser;
		stall = 1'b1;
		for (k = 0; k < 9; k++)
			put(2, 8'h50 + 8'(k));
		in_valid[2] = 1'b1;
		#1;
		`CHK("full refuses", 1'b0, in_ready[2])
		@(negedge clk);
		in_valid[2] = 1'b0;
		stall = 1'b0;
		repeat (100) @(negedge clk);
		`CHK("drained count", 9, n_ser - base)
	endtask : fill_drain

	// Serial bit enable period
	task automatic bit_rate();
		for (k = 0; k < 2000 && ser_bit_tick !== 1'b1; k++)
			@(negedge clk);
		@(negedge clk);
		for (k = 1; k < 2000 && ser_bit_tick !== 1'b1; k++)
			@(negedge clk);
		`CHK("bit period", BIT_CYC, k)
	endtask : bit_rate

	initial
	begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (6) @(negedge clk);
		`CHK("card usable bundle 1", 1'b1, card_usable)
		route(0, 8'h12, 4'hE, 1'b0);
		route(1, 8'h12, 4'hD, 1'b0);
		route(2, 8'h05, 4'h0, 1'b1);
		`CHK("own not global", 1'b0, cons_global)
		// A changed own address must be honoured, not a fixed value
		own_addr = 8'h12;
		route(0, 8'h12, 4'h0, 1'b1);
		own_addr = 8'h05;
		route(3, 8'hFF, 4'h7, 1'b1);
		`CHK("global flag", 1'b1, cons_global)
		reply(4'h8);
		bridge_en = 1'b0;
		route(0, 8'h33, 4'hC, 1'b0);
		route(1, 8'h33, 4'hC, 1'b0);
		bridge_en = 1'b1;
		slow = 1'b1;
		route(2, 8'h44, 4'hB, 1'b0);
		slow = 1'b0;
		bundle_num = 16'h0000;
		repeat (4) @(negedge clk);
		`CHK("bundle 0", 1'b0, card_usable)
		in_valid[1] = 1'b1;
		#1;
		`CHK("card port refused", 1'b0, in_ready[1])
		@(negedge clk);
		in_valid[1] = 1'b0;
		route(2, 8'h44, 4'h9, 1'b0);
		bundle_num = 16'h0100;
		repeat (4) @(negedge clk);
		`CHK("bundle 256", 1'b0, card_usable)
		bundle_num = 16'h00FF;
		repeat (4) @(negedge clk);
		`CHK("bundle 255", 1'b1, card_usable)
		card_pin = 1'b0;
		repeat (5) @(negedge clk);
		`CHK("card removed", 1'b0, card_usable)
		fill_drain();
		bit_rate();
		close_out();
	end
endmodule : test_cmr_router
